// *** cmp_ref_ctrl.sv ***
// comparator timer link and reference ladder control with an AXI4-Lite register slave
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RULE_01] sync bit latches comparator on timer falling edge
// [RULE_02] capture edge taken after timer prescaler
// [RULE_03] timer counts rising, capture on falling edge
// [RULE_04] sync clear passes comparator through unlatched
// [RULE_05] clock select: system clock or quarter rate
// [RULE_06] hysteresis bit enables comparator hysteresis
// [RULE_07] gate source resets one: pin, else comparator
// [RULE_08] unimplemented link control bits read zero
// [RULE_09] ladder select powers ladder, routes it; else fixed
// [RULE_10] ladder select low keeps divider powered down
// [RULE_11] range bit set low range, clear high
// [RULE_12] four bit level picks one of sixteen taps
// [RULE_13] fixed enable bit turns on fixed reference
// [RULE_14] fast oscillator running forces fixed reference on
// [RULE_15] both selects low put ground on reference
// [RULE_16] software waits settling delay after fixed enable
// [RULE_17] unimplemented writes ignored, documented reset values
module cmp_ref_ctrl
    import cmp_ref_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_result,
    input wire logic prescaler_enable,
    input wire logic [1:0] prescale_select,
    input wire logic fast_internal_oscillator,
    input wire logic external_gate_pin,
    output logic gated_timer_tick,
    output logic comparator_out,
    output logic gated_timer_gate,
    output logic hysteresis_enable,
    output logic timer_clock_alt_select,
    output logic ladder_reference_enable,
    output logic ladder_range_select,
    output logic [3:0] ladder_level,
    output logic fixed_reference_on,
    output logic [1:0] reference_mux_select
);
    typedef struct packed {
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] link_ctrl;
        logic [7:0] ladder_ctrl;
        logic [1:0] div_cnt;
        logic [2:0] pre_cnt;
        logic timer_clk_level;
        logic tick;
        logic cmp_latched;
        logic cmp_out;
        logic gate;
        logic fixed_on;
        ref_sel_t ref_sel;
    } state_t;

    state_t cur;
    state_t next_state;
    logic timer_src_edge;
    logic prescaled_edge;
    logic [3:0] pre_limit;
    logic do_write;

    // write waits for both address and data, response only after the previous one drained
    assign do_write = cur.aw_held && cur.w_held && !cur.bvalid;

    // prescaler ratios 1, 2, 4, 8 from the timer's prescale select
    assign pre_limit = prescaler_enable ? 4'(1 << prescale_select) : 4'h1;

    always_comb begin
        next_state = cur;
        timer_src_edge = 1'b0;
        prescaled_edge = 1'b0;
        // bus: address and data channels accepted in either order
        if (s_axi_awvalid && !cur.aw_held) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur.w_held) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (cur.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = resp_okay;
            // only implemented bits take the written value
            if (cur.aw_addr == link_ctrl_addr) begin
                if (cur.w_strb[0]) begin
                    next_state.link_ctrl = cur.w_data[7:0] & link_ctrl_mask; // [RULE_17]
                end
            end else if (cur.aw_addr == ladder_ctrl_addr) begin
                if (cur.w_strb[0]) begin
                    next_state.ladder_ctrl = cur.w_data[7:0] & ladder_ctrl_mask; // [RULE_17]
                end
            end else if (cur.aw_addr != status_addr) begin
                next_state.bresp = resp_slverr;
            end
        end
        // read channel: one outstanding read
        if (cur.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !cur.rvalid) begin
            next_state.rvalid = 1'b1;
            next_state.rresp = resp_okay;
            next_state.rdata = 32'h0;
            case (s_axi_araddr)
                link_ctrl_addr: next_state.rdata = {24'h0, cur.link_ctrl}; // [RULE_08]
                ladder_ctrl_addr: next_state.rdata = {24'h0, cur.ladder_ctrl};
                status_addr: next_state.rdata = {28'h0, cur.fixed_on, cur.gate,
                    cur.cmp_out, comparator_result};
                default: next_state.rresp = resp_slverr;
            endcase
        end
        // timer clock: full system rate or instruction clock at one quarter
        next_state.div_cnt = 2'(cur.div_cnt + 2'h1);
        if (cur.link_ctrl[clk_alt_bit]) begin
            timer_src_edge = 1'b1; // [RULE_05]
        end else begin
            timer_src_edge = (cur.div_cnt == 2'(instr_div - 1)); // [RULE_05]
        end
        // prescaled clock: tick marks the rising edge, level marks the falling half
        if (timer_src_edge) begin
            if (4'({1'b0, cur.pre_cnt}) + 4'h1 >= pre_limit) begin
                next_state.pre_cnt = 3'h0;
                prescaled_edge = 1'b1; // [RULE_02]
            end else begin
                next_state.pre_cnt = 3'(cur.pre_cnt + 3'h1);
            end
        end
        next_state.tick = prescaled_edge; // [RULE_03]
        // falling half follows the counting tick, so a capture always lags its count
        next_state.timer_clk_level = cur.tick; // [RULE_03]
        // capture in the falling half only; at full rate that is every cycle
        if (cur.timer_clk_level) begin
            next_state.cmp_latched = comparator_result; // [RULE_01]
        end
        if (cur.link_ctrl[sync_bit]) begin
            next_state.cmp_out = next_state.cmp_latched; // [RULE_01]
        end else begin
            next_state.cmp_out = comparator_result; // [RULE_04]
        end
        // gate: external pin or comparator output
        if (cur.link_ctrl[gate_src_bit]) begin
            next_state.gate = external_gate_pin; // [RULE_07]
        end else begin
            next_state.gate = next_state.cmp_out; // [RULE_07]
        end
        // fixed reference forced by fast oscillator
        next_state.fixed_on = cur.ladder_ctrl[fixed_en_bit] || fast_internal_oscillator; // [RULE_13] [RULE_14]
        if (cur.ladder_ctrl[ladder_sel_bit]) begin
            next_state.ref_sel = ref_ladder; // [RULE_09]
        end else if (cur.ladder_ctrl[fixed_en_bit]) begin
            next_state.ref_sel = ref_fixed; // [RULE_09]
        end else begin
            next_state.ref_sel = ref_ground; // [RULE_15]
        end
        if (!aresetn) begin
            next_state = '0;
            next_state.link_ctrl = link_ctrl_reset; // [RULE_07] [RULE_17]
            next_state.ladder_ctrl = ladder_ctrl_reset; // [RULE_17]
            next_state.gate = 1'b0;
            next_state.ref_sel = ref_ground;
        end
    end

    // single state register, synchronous reset folded into the next value
    always_ff @(posedge aclk) begin
        cur <= next_state;
    end

    // the sync output updates in the same cycle as the latch; only one flop between cause and pin
    assign s_axi_awready = !cur.aw_held;
    assign s_axi_wready = !cur.w_held;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = !cur.rvalid;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rresp = cur.rresp;
    assign s_axi_rdata = cur.rdata;
    assign gated_timer_tick = cur.tick;
    assign comparator_out = cur.cmp_out;
    assign gated_timer_gate = cur.gate;
    assign hysteresis_enable = cur.link_ctrl[hyst_bit]; // [RULE_06]
    assign timer_clock_alt_select = cur.link_ctrl[clk_alt_bit];
    assign ladder_reference_enable = cur.ladder_ctrl[ladder_sel_bit]; // [RULE_10]
    assign ladder_range_select = cur.ladder_ctrl[range_bit]; // [RULE_11]
    assign ladder_level = cur.ladder_ctrl[level_lsb +: 4]; // [RULE_12]
    assign fixed_reference_on = cur.fixed_on;
    assign reference_mux_select = cur.ref_sel;

    // checks next to the logic they guard
    // ladder may only be routed while its divider is powered
    a_divider_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_10]
        !ladder_reference_enable |=> reference_mux_select != ref_ladder)
        else $error("ladder routed while divider powered down");
    // both selects low ground the reference input
    a_ground_ref: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_15]
        (!cur.ladder_ctrl[ladder_sel_bit] && !cur.ladder_ctrl[fixed_en_bit])
        |=> reference_mux_select == ref_ground)
        else $error("reference not grounded");
    // ladder select wins the multiplexer
    a_ladder_route: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
        cur.ladder_ctrl[ladder_sel_bit] |=> reference_mux_select == ref_ladder)
        else $error("ladder not routed");
    // select low with fixed enabled routes the fixed reference
    a_fixed_route: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
        (!cur.ladder_ctrl[ladder_sel_bit] && cur.ladder_ctrl[fixed_en_bit])
        |=> reference_mux_select == ref_fixed)
        else $error("fixed reference not routed");
    // enable bit powers the fixed reference
    a_fixed_on: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
        cur.ladder_ctrl[fixed_en_bit] |=> fixed_reference_on)
        else $error("fixed reference not enabled");
    // neither enable nor fast oscillator: fixed reference off
    a_fixed_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
        (!cur.ladder_ctrl[fixed_en_bit] && !fast_internal_oscillator) |=> !fixed_reference_on)
        else $error("fixed reference not disabled");
    // fast oscillator overrides the enable bit
    a_fixed_force: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_14]
        fast_internal_oscillator |=> fixed_reference_on)
        else $error("fixed reference not forced on");
    // sync clear: output follows the raw result one cycle late
    a_async_pass: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
        !cur.link_ctrl[sync_bit] |=> comparator_out == $past(comparator_result))
        else $error("comparator not passed through");
    // falling half captures the raw result
    a_capture_edge: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
        cur.timer_clk_level |=> cur.cmp_latched == $past(comparator_result))
        else $error("comparator not captured on falling half");
    // a count edge with no falling half pending leaves the latch alone
    a_no_coincide: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
        (cur.tick && !cur.timer_clk_level) |=> $stable(cur.cmp_latched))
        else $error("capture coincides with count");
    // gate source set: gate follows the pin
    a_gate_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
        cur.link_ctrl[gate_src_bit] |=> gated_timer_gate == $past(external_gate_pin))
        else $error("gate not from pin");
    // system clock source ticks every cycle without prescaler
    a_fast_tick: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
        (cur.link_ctrl[clk_alt_bit] && !prescaler_enable) [*2] |=> gated_timer_tick)
        else $error("timer tick missing at system rate");
    // instruction clock never ticks on two cycles in a row
    a_instr_spacing: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_05]
        (!$past(cur.link_ctrl[clk_alt_bit]) && !$past(cur.link_ctrl[clk_alt_bit], 2))
        |-> !(cur.tick && $past(cur.tick)))
        else $error("instruction clock ticks too close");
    // unimplemented positions stay zero
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
        (cur.link_ctrl & ~link_ctrl_mask) == 8'h00 && cur.ladder_ctrl[6] == 1'b0)
        else $error("reserved bit set");
    // reset loads the documented register values
    a_reset_value: assert property (@(posedge aclk) // [RULE_17]
        !aresetn |=> (cur.link_ctrl == link_ctrl_reset && cur.ladder_ctrl == ladder_ctrl_reset))
        else $error("register reset value wrong");

    // main scenarios worth seeing
    c_sync_capture: cover property (@(posedge aclk) disable iff (!aresetn)
        cur.link_ctrl[sync_bit] && $changed(comparator_out));
    c_write_done: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready);
    c_read_done: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);
    c_slverr_write: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bresp == resp_slverr);
    c_forced_fixed: cover property (@(posedge aclk) disable iff (!aresetn)
        fast_internal_oscillator && !cur.ladder_ctrl[fixed_en_bit] ##1 fixed_reference_on);
endmodule // cmp_ref_ctrl
`default_nettype wire

// *** cmp_ref_pkg.sv ***
// package: register map, field positions and reset values of the comparator reference control
package cmp_ref_pkg;
    // register byte addresses on the AXI4-Lite bus
    localparam logic [3:0] link_ctrl_addr = 4'h0;
    localparam logic [3:0] ladder_ctrl_addr = 4'h4;
    localparam logic [3:0] status_addr = 4'h8;
    // timer link control fields
    localparam int sync_bit = 0;
    localparam int gate_src_bit = 1;
    localparam int hyst_bit = 3;
    localparam int clk_alt_bit = 4;
    localparam logic [7:0] link_ctrl_mask = 8'h1B;
    localparam logic [7:0] link_ctrl_reset = 8'h02;
    // reference ladder control fields
    localparam int level_lsb = 0;
    localparam int fixed_en_bit = 4;
    localparam int range_bit = 5;
    localparam int ladder_sel_bit = 7;
    localparam logic [7:0] ladder_ctrl_mask = 8'hBF;
    localparam logic [7:0] ladder_ctrl_reset = 8'h00;
    // instruction clock is the system clock divided by this
    localparam int instr_div = 4;
    // reference multiplexer choices
    typedef enum logic [1:0] {
        ref_ground,
        ref_fixed,
        ref_ladder
    } ref_sel_t;
    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// *** comparator_sync_vref_control_test.sv ***
// self-checking bench for the comparator timer link and reference control
`timescale 1ns/10ps
`default_nettype none
module comparator_sync_vref_control_test;
    import cmp_ref_pkg::*;
    logic aclk = 1'h0, aresetn = 1'h0, set_level = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, prescaler_enable = 1'h0;
    logic [1:0] prescale_select = 2'h0, s_axi_bresp, s_axi_rresp, reference_mux_select;
    logic fast_internal_oscillator = 1'h0, external_gate_pin = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic comparator_result, gated_timer_tick, comparator_out, gated_timer_gate;
    logic hysteresis_enable, timer_clock_alt_select, ladder_reference_enable;
    logic ladder_range_select, fixed_reference_on;
    logic [3:0] ladder_level;
    logic [15:0] tick_count;
    logic [31:0] d;
    logic [1:0] r;
    int mismatches = 0, cmp_count = 0;
    cmp_ref_ctrl cmp_ref_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_result,
        .prescaler_enable, .prescale_select, .fast_internal_oscillator, .external_gate_pin,
        .gated_timer_tick, .comparator_out, .gated_timer_gate, .hysteresis_enable,
        .timer_clock_alt_select, .ladder_reference_enable, .ladder_range_select, .ladder_level,
        .fixed_reference_on, .reference_mux_select);
    timer_front_model timer_front_model_inst (.aclk, .aresetn, .gated_timer_tick, .set_level,
        .comparator_result, .tick_count);
    // 200 MHz system clock
    always #2.5 aclk = ~aclk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            aw_ok |= s_axi_awready;
            w_ok |= s_axi_wready;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        repeat (2) @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic t_regs;
        rd(link_ctrl_addr);
        chk("link reset", d, 32'h00000002);
        wr(link_ctrl_addr, 32'hFFFFFFFF);
        rd(link_ctrl_addr);
        chk("link masked", d, 32'h0000001B);
        chk("hysteresis", hysteresis_enable, 32'h1);
        chk("clock alt", timer_clock_alt_select, 32'h1);
        wr(ladder_ctrl_addr, 32'hFFFFFFFF);
        rd(ladder_ctrl_addr);
        chk("ladder masked", d, 32'h000000BF);
        chk("level", ladder_level, 32'hF);
        chk("range", ladder_range_select, 32'h1);
        wr(ladder_ctrl_addr, 32'h00000009);
        chk("level nine", ladder_level, 32'h9);
        chk("range high", ladder_range_select, 32'h0);
        // low byte lane off: the register must keep its value
        s_axi_wstrb <= 4'h0;
        wr(ladder_ctrl_addr, 32'hFFFFFFFF);
        s_axi_wstrb <= 4'hF;
        rd(ladder_ctrl_addr);
        chk("strobe off", d, 32'h00000009);
        wr(4'hC, 32'hFFFFFFFF);
        chk("bad write resp", r, resp_slverr);
        rd(4'hC);
        chk("bad read resp", r, resp_slverr);
        chk("bad read data", d, 32'h0);
    endtask
    // ticks in a 64-cycle span, a multiple of every period used, so phase does not matter
    task automatic cnt(input logic [31:0] link, input logic pe, input logic [1:0] ps, input int n);
        logic [15:0] c;
        wr(link_ctrl_addr, link);
        prescaler_enable <= pe;
        prescale_select <= ps;
        repeat (8) @(posedge aclk);
        c = tick_count;
        repeat (64) @(posedge aclk);
        chk("ticks", tick_count - c, n);
    endtask
    task automatic t_sync;
        wr(link_ctrl_addr, 32'h00000000);
        set_level <= 1'h1;
        repeat (4) @(posedge aclk);
        chk("async out", comparator_out, 32'h1);
        chk("gate from cmp", gated_timer_gate, 32'h1);
        chk("hysteresis off", hysteresis_enable, 32'h0);
        chk("clock alt off", timer_clock_alt_select, 32'h0);
        wr(link_ctrl_addr, 32'h00000001);
        prescaler_enable <= 1'h1;
        prescale_select <= 2'h3;
        do @(posedge aclk); while (!gated_timer_tick);
        repeat (4) @(posedge aclk);
        set_level <= 1'h0;
        repeat (20) begin
            @(posedge aclk);
            chk("held between ticks", comparator_out, 32'h1);
        end
        do @(posedge aclk); while (!gated_timer_tick);
        repeat (4) @(posedge aclk);
        chk("captured", comparator_out, 32'h0);
        wr(link_ctrl_addr, 32'h00000002);
        external_gate_pin <= 1'h1;
        repeat (4) @(posedge aclk);
        chk("gate from pin", gated_timer_gate, 32'h1);
        // status: fixed off, gate high, output and raw result low
        rd(status_addr);
        chk("status", d, 32'h00000004);
    endtask
    task automatic t_ref;
        wr(ladder_ctrl_addr, 32'h00000000);
        chk("mux ground", reference_mux_select, ref_ground);
        chk("divider off", ladder_reference_enable, 32'h0);
        chk("fixed off", fixed_reference_on, 32'h0);
        fast_internal_oscillator <= 1'h1;
        repeat (4) @(posedge aclk);
        chk("forced fixed", fixed_reference_on, 32'h1);
        chk("forced mux ground", reference_mux_select, ref_ground);
        fast_internal_oscillator <= 1'h0;
        wr(ladder_ctrl_addr, 32'h00000010);
        repeat (8) @(posedge aclk);
        chk("fixed on", fixed_reference_on, 32'h1);
        chk("mux fixed", reference_mux_select, ref_fixed);
        wr(ladder_ctrl_addr, 32'h00000090);
        chk("mux ladder", reference_mux_select, ref_ladder);
        chk("divider on", ladder_reference_enable, 32'h1);
    endtask
    // mid-run reset must restore both registers
    task automatic t_reset;
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(link_ctrl_addr);
        chk("link after reset", d, 32'h00000002);
        rd(ladder_ctrl_addr);
        chk("ladder after reset", d, 32'h00000000);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs;
        cnt(32'h00000000, 1'h0, 2'h0, 16);
        cnt(32'h00000010, 1'h0, 2'h0, 64);
        cnt(32'h00000010, 1'h1, 2'h2, 16);
        t_sync;
        t_ref;
        t_reset;
        complete_run;
    end
endmodule // comparator_sync_vref_control_test
`default_nettype wire

// *** timer_front_model.sv ***
// behavioural gated timer counter and comparator front end facing the control block
`timescale 1ns/10ps
`default_nettype none
module timer_front_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic gated_timer_tick,
    input wire logic set_level,
    output logic comparator_result,
    output logic [15:0] tick_count
);
    // the counter only moves on the rising-edge tick, so a capture one cycle after the tick never races it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_count <= 16'h0000;
        end else if (gated_timer_tick) begin
            tick_count <= tick_count + 16'h0001;
        end
    end
    // comparator decision settles just after an edge, like a real analog output
    always_ff @(posedge aclk) begin
        comparator_result <= set_level;
    end
endmodule // timer_front_model
`default_nettype wire
